// ===== design/ldcs_pkg.sv
// package: constants and carriers for the led display control sequencer
package ldcs_pkg;
    // command classes held in the top two bits of a command byte
    localparam logic [1:0] CMD_MODE = 2'h0;
    localparam logic [1:0] CMD_DATA = 2'h1;
    localparam logic [1:0] CMD_CTRL = 2'h2;
    localparam logic [1:0] CMD_ADDR = 2'h3;
    // display control byte fields
    localparam int CTRL_ON_BIT = 3;
    localparam logic [2:0] DIM_RESET = 3'h0;
    // data setting byte fields
    localparam int DATA_FIXED_BIT = 2;
    localparam logic [1:0] RW_READ = 2'h2;
    // display ram
    localparam int RAM_WORDS = 14;
    localparam logic [3:0] ADDR_LAST = 4'hD;
    localparam logic [1:0] MODE_RESET = 2'h3;
    // key data: five bytes of three pairs
    localparam int KEY_BYTES = 5;
    // display timing: ticks per grid slot and grids per frame
    localparam int TICKS_PER_SLOT = 16;
    localparam logic [4:0] TICKS_LAST = 5'hF;
    localparam int GRIDS = 7;
    localparam logic [2:0] GRID_LAST = 3'h6;
    // oscillator tick divider: 100 MHz down to about 500 kHz
    localparam int CLK_MHZ = 100;
    localparam int TICK_NS = 2000;
    localparam int TICK_DIV = (TICK_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] TICK_DIV_LAST = 8'(TICK_DIV - 1);

    // settings held by the control command
    typedef struct packed {
        logic on;
        logic [2:0] dim;
    } ldcs_ctrl_t;

    // one received serial byte
    typedef struct packed {
        logic first;
        logic [7:0] data;
    } ldcs_byte_t;
endpackage

// ===== design/ldcs_serial_rx.sv
// serial front end: synchronises the pins, shifts bytes in and key data out
`timescale 1ns/1ns
`default_nettype none
module ldcs_serial_rx
    import ldcs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins from the host
    input wire logic frame_select,
    input wire logic sclk,
    input wire logic din,
    // read data to shift out
    input wire logic [7:0] tx_byte,
    // received byte strobe and byte, reload strobe and data-out drive
    output logic rx_valid,
    output ldcs_byte_t rx_byte,
    output logic tx_load,
    output logic dout_oe
);
    logic [2:0] stb_s1_r, stb_s2_r;
    logic sclk_d_r, first_r, load_pend_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] sh_r, tx_r;
    logic rise, fall, stb_hi;

    // two-flop synchronisers on strobe, clock and data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stb_s1_r <= 3'h7;
            stb_s2_r <= 3'h7;
        end else begin
            stb_s1_r <= {frame_select, sclk, din};
            stb_s2_r <= stb_s1_r;
        end
    end

    assign stb_hi = stb_s2_r[2];
    assign rise = stb_s2_r[1] & ~sclk_d_r & ~stb_hi;
    assign fall = ~stb_s2_r[1] & sclk_d_r & ~stb_hi;

    // edge history; clock edges while strobe is high are ignored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d_r <= 1'b1;
        end else begin
            sclk_d_r <= stb_s2_r[1];
        end
    end

    // shift in lsb first on rising edges; strobe high drops a partial byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_r <= 3'h0;
            sh_r <= 8'h00;
            first_r <= 1'b1;
            rx_valid <= 1'b0;
            rx_byte <= '0;
        end else begin
            rx_valid <= 1'b0;
            if (stb_hi) begin
                bit_cnt_r <= 3'h0;
                first_r <= 1'b1;
            end else if (rise) begin
                sh_r <= {stb_s2_r[0], sh_r[7:1]};
                bit_cnt_r <= bit_cnt_r + 3'h1;
                if (bit_cnt_r == 3'h7) begin
                    rx_valid <= 1'b1;
                    rx_byte <= '{first: first_r,
                                 data: {stb_s2_r[0], sh_r[7:1]}};
                    first_r <= 1'b0;
                end
            end
        end
    end

    // a byte boundary arms the reload; it is done at the next fall so that
    // a read command ending at this rise has already been decoded
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            load_pend_r <= 1'b0;
        end else if (stb_hi) begin
            load_pend_r <= 1'b0;
        end else if (rise & bit_cnt_r == 3'h7) begin
            load_pend_r <= 1'b1;
        end else if (fall) begin
            load_pend_r <= 1'b0;
        end
    end

    assign tx_load = fall & load_pend_r;

    // shift out on falling edges; open drain pulls low for a zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_r <= 8'hFF;
            dout_oe <= 1'b0;
        end else if (stb_hi) begin
            dout_oe <= 1'b0;
            tx_r <= 8'hFF;
        end else if (tx_load) begin
            dout_oe <= ~tx_byte[0];
            tx_r <= {1'b1, tx_byte[7:1]};
        end else if (fall) begin
            dout_oe <= ~tx_r[0];
            tx_r <= {1'b1, tx_r[7:1]};
        end
    end
endmodule
`default_nettype wire

// ===== design/ldcs_top.sv
// top: command decode, display ram, multiplex drive and key scan
`timescale 1ns/1ns
`default_nettype none
module ldcs_top
    import ldcs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial port
    input wire logic frame_select,
    input wire logic sclk,
    input wire logic din,
    output logic dout_oe,
    // key matrix
    input wire logic [2:0] key_return_lines,
    // display drive
    output logic [13:0] segment_key_source_lines,
    output logic [6:0] grid_lines,
    // status
    output logic display_on,
    output logic [1:0] display_mode
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ = 3'b100
    } ldcs_state_t;

    ldcs_state_t state_r;
    ldcs_ctrl_t ctrl_r;
    logic scan_en_r, fixed_r, blank_r;
    logic [1:0] mode_r;
    logic [3:0] addr_r;
    logic [7:0] ram_r [RAM_WORDS];
    logic [7:0] key_r [KEY_BYTES];
    logic [2:0] key_idx_r;
    logic rx_valid, tx_load;
    ldcs_byte_t rx_byte;
    logic [7:0] tx_byte;
    logic [7:0] div_r;
    logic tick;
    logic [4:0] tick_r;
    logic [2:0] grid_r;
    logic frame_r;
    logic [2:0] kin_s1_r, kin_s2_r;
    logic [15:0] seg_word;
    logic [4:0] on_ticks;

    // on-time in sixteenths for each dim code
    function automatic logic [4:0] dim_ticks(input logic [2:0] code);
        case (code)
            3'h0: dim_ticks = 5'h01;
            3'h1: dim_ticks = 5'h02;
            3'h2: dim_ticks = 5'h04;
            3'h3: dim_ticks = 5'h0A;
            3'h4: dim_ticks = 5'h0B;
            3'h5: dim_ticks = 5'h0C;
            3'h6: dim_ticks = 5'h0D;
            default: dim_ticks = 5'h0E;
        endcase
    endfunction

    ldcs_serial_rx u_rx (
        .clk(clk),
        .rst_n(rst_n),
        .frame_select(frame_select),
        .sclk(sclk),
        .din(din),
        .tx_byte(tx_byte),
        .rx_valid(rx_valid),
        .rx_byte(rx_byte),
        .tx_load(tx_load),
        .dout_oe(dout_oe)
    );

    // command decode and control state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= '{on: 1'b0, dim: DIM_RESET};
            scan_en_r <= 1'b0;
            blank_r <= 1'b0;
            mode_r <= MODE_RESET;
            fixed_r <= 1'b0;
            state_r <= ST_IDLE;
        end else if (rx_valid && rx_byte.first) begin
            case (rx_byte.data[7:6])
                CMD_CTRL: begin
                    // bits 5:4 are don't care
                    ctrl_r.on <= rx_byte.data[CTRL_ON_BIT];
                    ctrl_r.dim <= rx_byte.data[2:0];
                    scan_en_r <= 1'b1;
                    blank_r <= 1'b0;
                end
                CMD_MODE: begin
                    if (rx_byte.data[1:0] != mode_r) begin
                        blank_r <= 1'b1;
                    end
                    mode_r <= rx_byte.data[1:0];
                end
                CMD_DATA: begin
                    fixed_r <= rx_byte.data[DATA_FIXED_BIT];
                    state_r <= (rx_byte.data[1:0] == RW_READ) ?
                        ST_READ : ST_WRITE;
                end
                default: state_r <= ST_WRITE;
            endcase
        end
    end

    // address pointer and display ram writes; ram is not cleared
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_r <= 4'h0;
        end else if (rx_valid) begin
            if (rx_byte.first && rx_byte.data[7:6] == CMD_ADDR) begin
                addr_r <= rx_byte.data[3:0];
            end else if (!rx_byte.first && state_r == ST_WRITE &&
                         addr_r <= ADDR_LAST) begin
                if (!fixed_r) begin
                    addr_r <= addr_r + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rx_valid && !rx_byte.first && state_r == ST_WRITE &&
            addr_r <= ADDR_LAST) begin
            ram_r[addr_r] <= rx_byte.data;
        end
    end

    // key read pointer: restarts at each command, steps per byte shifted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            key_idx_r <= 3'h0;
        end else if (rx_valid && rx_byte.first) begin
            key_idx_r <= 3'h0;
        end else if (tx_load && state_r == ST_READ &&
                     key_idx_r < 3'(KEY_BYTES)) begin
            key_idx_r <= key_idx_r + 3'h1;
        end
    end

    assign tx_byte = (state_r == ST_READ && key_idx_r < 3'(KEY_BYTES)) ?
        key_r[key_idx_r] : 8'hFF;

    // tick divider standing in for the rc oscillator
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 8'h00;
        end else begin
            div_r <= (div_r == TICK_DIV_LAST) ? 8'h00 : div_r + 8'h01;
        end
    end
    assign tick = (div_r == TICK_DIV_LAST);

    // slot, grid and frame counters; two frames per key scan
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_r <= 5'h00;
            grid_r <= 3'h0;
            frame_r <= 1'b0;
        end else if (tick && scan_en_r) begin
            if (tick_r == TICKS_LAST) begin
                tick_r <= 5'h00;
                if (grid_r == GRID_LAST) begin
                    grid_r <= 3'h0;
                    frame_r <= ~frame_r;
                end else begin
                    grid_r <= grid_r + 3'h1;
                end
            end else begin
                tick_r <= tick_r + 5'h01;
            end
        end
    end

    // key return synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            kin_s1_r <= 3'h0;
            kin_s2_r <= 3'h0;
        end else begin
            kin_s1_r <= key_return_lines;
            kin_s2_r <= kin_s1_r;
        end
    end

    // latch keys at the last tick of each of the first five slots: bits 2:0 in the first frame, bits 5:3 in the second
    always_ff @(posedge clk) begin
        if (tick && scan_en_r && frame_r && tick_r == TICKS_LAST &&
            grid_r < 3'h5) begin
            key_r[grid_r] <= {2'b00, kin_s2_r, key_r[grid_r][2:0]};
        end else if (tick && scan_en_r && !frame_r &&
                     tick_r == TICKS_LAST && grid_r < 3'h5) begin
            key_r[grid_r][2:0] <= kin_s2_r;
        end
    end

    assign seg_word = {ram_r[{grid_r, 1'b1}], ram_r[{grid_r, 1'b0}]};
    assign on_ticks = dim_ticks(ctrl_r.dim);

    // drive: frame 0 lights segments, frame 1 walks key sources
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            segment_key_source_lines <= 14'h0000;
            grid_lines <= 7'h00;
        end else if (!frame_r && ctrl_r.on && !blank_r &&
                     tick_r < on_ticks) begin
            segment_key_source_lines <= seg_word[13:0];
            grid_lines <= 7'(7'h01 << grid_r);
        end else if (frame_r && scan_en_r && grid_r < 3'h5) begin
            segment_key_source_lines <= 14'(14'h0003 << {grid_r, 1'b0});
            grid_lines <= 7'h00;
        end else begin
            segment_key_source_lines <= 14'h0000;
            grid_lines <= 7'h00;
        end
    end

    assign display_on = ctrl_r.on & ~blank_r;
    assign display_mode = mode_r;

    // lit outputs only while the display is switched on
    off_dark_a: assert property (@(posedge clk)
        disable iff (!rst_n) !ctrl_r.on |=> grid_lines == 7'h00)
        else $error("grid driven while display off");
    blank_hold_a: assert property (@(posedge clk)
        disable iff (!rst_n) blank_r |=> grid_lines == 7'h00)
        else $error("grid driven while blanked");
    // width judged against the dim code in force when the drive was set
    dim_width_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        (grid_lines != 7'h00) |-> $past(tick_r) < $past(on_ticks))
        else $error("segment lit beyond dim width");
    ctrl_take_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        rx_valid && rx_byte.first && rx_byte.data[7:6] == CMD_CTRL
        |=> ctrl_r.dim == $past(rx_byte.data[2:0]) && scan_en_r)
        else $error("control byte not taken");
    ctrl_on_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        rx_valid && rx_byte.first && rx_byte.data[7:6] == CMD_CTRL
        |=> ctrl_r.on == $past(rx_byte.data[3]))
        else $error("on bit not taken");
    scan_idle_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        !scan_en_r |-> tick_r == 5'h00 && grid_r == 3'h0)
        else $error("scan running before first control");
    slot_len_a: assert property (@(posedge clk)
        disable iff (!rst_n) tick_r <= TICKS_LAST)
        else $error("slot tick out of range");
    dim_map_a: assert property (@(posedge clk)
        disable iff (!rst_n) ctrl_r.dim == 3'h3 |-> on_ticks == 5'h0A)
        else $error("dim code 3 maps wrongly");
    key_source_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        (segment_key_source_lines != 14'h0000 && grid_lines == 7'h00)
        |-> $past(frame_r))
        else $error("key source outside scan frame");
endmodule
`default_nettype wire

// ===== bench/ldcs_host.sv
// host model: drives strobe, link clock and data, reads open-drain data
`timescale 1ns/1ns
`default_nettype none
module ldcs_host (
    // bench clock, used only to pace the link
    input wire logic clk,
    // serial pins
    output logic frame_select,
    output logic sclk,
    output logic din,
    input wire logic dout
);
    // link clock stands high outside frames
    initial begin
        frame_select = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
    end
    // half of the 80 ns link period, launched just after a bench edge
    task automatic half(input int n);
        repeat (4 * n) @(posedge clk);
        #1;
    endtask
    // n bits of one byte, lsb first, data set up while the clock is low
    task automatic bits(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            sclk = 1'b0;
            din = b[i];
            half(1);
            sclk = 1'b1;
            half(1);
        end
    endtask
    // strobe high again; 1 us each side keeps clock-strobe and pulse width
    task automatic close();
        half(25);
        frame_select = 1'b1;
        din = ~din; // a released line must not keep its last value
        half(26);
    endtask
    // first byte is the command, the rest data; nbits < 8 aborts mid-byte
    task automatic frame(input logic [7:0] b[$], input int nbits);
        frame_select = 1'b0;
        half(1);
        foreach (b[k]) bits(b[k], nbits < 8 ? nbits : 8);
        close();
    endtask
    // key read: command, then at least 1 us before the first data fall
    task automatic rd(input logic [7:0] cmd, output logic [7:0] r[5]);
        frame_select = 1'b0;
        half(1);
        bits(cmd, 8);
        half(26);
        for (int i = 0; i < 40; i++) begin
            sclk = 1'b0;
            half(1);
            sclk = 1'b1;
            half(1);
            r[i / 8][i % 8] = dout; // late in the high phase
        end
        close();
    endtask
endmodule
`default_nettype wire

// ===== bench/test_led_display_control_sequencer.sv
// testbench: drives the host model and scores the display outputs
`timescale 1ns/1ns
`default_nettype none
module test_led_display_control_sequencer;
    import ldcs_pkg::*;
    typedef struct packed {
        logic [1:0] kind;
        logic [15:0] val;
    } ldcs_exp_t;
    logic clk, rst_n, dout_oe, display_on, frame_select, sclk, din, busy;
    logic [2:0] key_return_lines;
    logic [13:0] segs;
    logic [6:0] grids;
    logic [1:0] display_mode;
    logic [7:0] kd [5];
    logic [7:0] d[$];
    logic [3:0] ticks [8] = '{1, 2, 4, 10, 11, 12, 13, 14};
    int n_mismatch = 0, comparisons = 0, cycles = 0, ki = 0;
    ldcs_exp_t q[$];
    // data-out has a pull-up: high unless the device pulls it low
    wire logic dout_line = ~dout_oe;

    ldcs_top uut (.clk(clk), .rst_n(rst_n), .frame_select(frame_select),
        .sclk(sclk), .din(din), .dout_oe(dout_oe),
        .key_return_lines(key_return_lines),
        .segment_key_source_lines(segs), .grid_lines(grids),
        .display_on(display_on), .display_mode(display_mode));
    ldcs_host h (.clk(clk), .frame_select(frame_select), .sclk(sclk),
        .din(din), .dout(dout_line));

    // 100 MHz bench clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (n_mismatch == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // note an expectation and wait until the monitor has scored it
    task automatic expect_res(input logic [1:0] kind, input logic [15:0] v);
        q.push_back({kind, v});
        wait (q.size() == 0 && !busy);
    endtask

    // lit cycles with a grid and a segment on, in whole ticks of 200 clk
    task automatic lit(input int n, output logic [15:0] t);
        int c;
        c = 0;
        repeat (n) begin
            @(negedge clk);
            if (grids != 7'h00 && segs != 14'h0000) c++;
        end
        t = 16'((c + 100) / 200);
    endtask

    // monitor: measures the result of the oldest note and compares it
    initial begin
        ldcs_exp_t e;
        logic [15:0] obs;
        logic [6:0] g;
        busy = 1'b0;
        forever begin
            wait (q.size() != 0);
            busy = 1'b1;
            e = q[0];
            obs = {13'h0000, display_on, display_mode};
            if (e.kind == 2'h1) begin
                // sync to a fresh grid slot so one whole slot is counted
                g = grids;
                @(negedge clk);
                while (grids == g || grids == 7'h00) begin
                    g = grids;
                    @(negedge clk);
                end
                lit(3200, obs);
            end
            if (e.kind == 2'h2) lit(6400, obs);
            if (e.kind == 2'h3) begin
                obs = {8'h00, kd[ki] & 8'h3F};
                ki++;
            end
            check(obs, e.val);
            void'(q.pop_front());
            busy = 1'b0;
        end
    end

    // timeout guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 300000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    initial begin
        logic [2:0] c;
        rst_n = 1'b0;
        key_return_lines = 3'h0;
        void'($urandom(32'hEFD9));
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        key_return_lines = 3'($urandom());
        repeat (3) @(posedge clk);
        #1;
        expect_res(2'h0, {13'h0, 1'b0, MODE_RESET});
        expect_res(2'h2, 16'h0000);
        // write mode, clear all ram by incrementing address
        h.frame('{8'h40}, 8);
        d = '{8'hC0};
        repeat (14) d.push_back(8'h00);
        h.frame(d, 8);
        h.frame('{8'h03}, 8); // same mode: no blanking
        h.frame('{8'h87}, 8);
        h.frame('{8'h03}, 8);
        h.frame('{8'h8F}, 8);
        expect_res(2'h1, 16'h0000);
        // fixed addressing, one byte to every location
        h.frame('{8'h44}, 8);
        for (int a = 0; a < 14; a++) h.frame('{8'hC0 | 8'(a), 8'hFF}, 8);
        // every dimming code with random ignored bits 5:4
        for (int k = 0; k < 8; k++) begin
            c = 3'(k);
            h.frame('{8'h88 | {2'h0, 2'($urandom()), 4'h0} | c}, 8);
            expect_res(2'h0, {13'h0, 1'b1, MODE_RESET});
            if (c == 3'h0 || c == 3'h3 || c == 3'h7)
                expect_res(2'h1, 16'(ticks[k]));
        end
        // strobe high mid-byte: the partial byte is dropped
        h.frame('{8'h80}, 4);
        expect_res(2'h0, {13'h0, 1'b1, MODE_RESET});
        // mode change blanks until the next control command
        h.frame('{8'h02}, 8);
        expect_res(2'h0, {13'h0, 1'b0, 2'h2});
        h.frame('{8'h8F}, 8);
        h.frame('{8'h02}, 8);
        expect_res(2'h0, {13'h0, 1'b1, 2'h2});
        // display off: grid drivers idle, key scan keeps running
        key_return_lines = 3'($urandom());
        h.frame('{8'hB5}, 8);
        expect_res(2'h0, {13'h0, 1'b0, 2'h2});
        expect_res(2'h2, 16'h0000);
        // with the window above this spans one whole two-frame key scan
        repeat (38600) @(posedge clk);
        #1;
        h.rd({6'h10, RW_READ}, kd);
        for (int i = 0; i < KEY_BYTES; i++)
            expect_res(2'h3, {10'h000, key_return_lines, key_return_lines});
        report_and_stop();
    end
endmodule
`default_nettype wire
